// *** verilog/ebcr_pkg.sv ***
// constants and types of the echo-buffer and capacity command handler
// assumes a cdb of 16 bytes, byte 0 in the top bits of a 128-bit word
package ebcr_pkg;

    // operation codes and sub-codes
    localparam logic [7:0] OPC_READ_BUFFER = 8'h3c;
    localparam logic [7:0] OPC_READ_CAP10  = 8'h25;
    localparam logic [7:0] OPC_SVC_IN16    = 8'h9e;
    localparam logic [4:0] SA_READ_CAP16   = 5'h10;
    localparam logic [4:0] MODE_ECHO_READ  = 5'h0a;
    localparam logic [4:0] MODE_ECHO_DESC  = 5'h0b;
    localparam logic [4:0] MODE_EXP_ECHO   = 5'h1a;

    // cdb byte positions
    localparam int CDB_OPCODE      = 0;
    localparam int CDB_MODE_SA     = 1;
    localparam int RB_OFFSET_BYTE  = 3;
    localparam int RB_OFFSET_LEN   = 3;
    localparam int RB_ALLOC_BYTE   = 6;
    localparam int RB_ALLOC_LEN    = 3;
    localparam int RB_ALLOC_LSB    = 8;
    localparam int RC10_LBA_BYTE   = 2;
    localparam int RC10_LBA_LEN    = 4;
    localparam int RC10_PMI_BYTE   = 8;
    localparam int RC16_LBA_BYTE   = 2;
    localparam int RC16_LBA_LEN    = 8;
    localparam int RC16_ALLOC_BYTE = 10;
    localparam int RC16_ALLOC_LEN  = 4;
    localparam int RC16_PMI_BYTE   = 14;

    // sense data
    localparam logic [3:0] SK_NONE        = 4'h0;
    localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
    localparam logic [7:0] ASC_NONE       = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD  = 8'h24;
    localparam logic [7:0] ASC_SEQ_ERROR  = 8'h2c;

    // reply sizes and field limits
    localparam logic [8:0]  LEN_CAP10     = 9'h008;
    localparam logic [8:0]  LEN_CAP16     = 9'h020;
    localparam logic [8:0]  LEN_ECHO_DESC = 9'h004;
    localparam logic [47:0] LBA_CEILING   = 48'hffff_ffff_ffff;
    localparam logic [15:0] ALIGNED_MAX   = 16'h3fff;
    localparam logic [2:0]  PTYPE_MAX     = 3'h2;
    localparam logic        ECHO_OVERWRITE_SUPPORTED_FLAG = 1'b0;
    localparam int          ECHO_DEPTH_DEF = 256;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_STAT = 3'b100
    } ebcr_state_t;

    typedef enum logic [1:0] {
        SRC_ECHO  = 2'h0,
        SRC_DESC  = 2'h1,
        SRC_CAP10 = 2'h2,
        SRC_CAP16 = 2'h3
    } ebcr_src_t;

endpackage : ebcr_pkg

// *** verilog/ebcr_echo_mem.sv ***
// echo storage: one write port, asynchronous read port
// assumes the caller keeps addresses below DEPTH
`timescale 1ns/10ps
module ebcr_echo_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          clk_sys,
    // write side
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [7:0]    wrData,
    // read side
    input  wire logic [AW-1:0] rdAddr,
    output logic      [7:0]    rdData
);
    logic [7:0] mem [DEPTH];

    // contents need no reset: reads before a write are undefined anyway
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdData = mem[rdAddr];
endmodule : ebcr_echo_mem

// *** verilog/ebcr_cap_fmt.sv ***
// capacity reply formatter: picks one byte of the 8 or 32 byte reply
// assumes all fields are already clamped and encoded by the caller
`timescale 1ns/10ps
module ebcr_cap_fmt (
    // selection
    input  wire logic        isLong,
    input  wire logic [4:0]  idx,
    // fields
    input  wire logic [63:0] lba64,
    input  wire logic [31:0] lba32,
    input  wire logic [31:0] blockLen,
    input  wire logic [7:0]  protByte,
    input  wire logic [7:0]  expByte,
    input  wire logic        thinProvisioningEnabled,
    input  wire logic        unmappedReadsZero,
    input  wire logic [13:0] lowestAligned,
    // result
    output logic      [7:0]  replyByte
);
    logic [255:0] longReply;
    logic [63:0]  shortReply;

    always_comb begin
        // big-endian: byte 0 sits in the top bits
        longReply  = {lba64, blockLen, protByte, expByte,
                      thinProvisioningEnabled, unmappedReadsZero,
                      lowestAligned, 128'h0};
        shortReply = {lba32, blockLen};
        if (isLong) begin
            replyByte = longReply[8'(255 - 8 * idx) -: 8];
        end else begin
            replyByte = shortReply[6'(63 - 8 * idx[2:0]) -: 8];
        end
    end
endmodule : ebcr_cap_fmt

// *** verilog/ebcr_top.sv ***
// echo-buffer read modes and capacity queries of a block storage target
// assumes the transport hands over a whole cdb and drains a byte stream
`timescale 1ns/10ps
module ebcr_top
    import ebcr_pkg::*;
#(
    parameter int ECHO_DEPTH = ebcr_pkg::ECHO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    // command in
    input  wire logic          cmdValid,
    input  wire logic [127:0]  cmdCdb,
    output logic               cmdReady,
    // echo write stream from the write-buffer handler
    input  wire logic          echoWrStart,
    input  wire logic          echoWrValid,
    input  wire logic [7:0]    echoWrData,
    // data-in stream
    output logic               dinValid,
    output logic      [7:0]    dinData,
    output logic               dinLast,
    input  wire logic          dinReady,
    // completion
    output logic               doneValid,
    output logic               doneCheck,
    output logic      [3:0]    senseKey,
    output logic      [7:0]    senseAsc,
    output logic               echoHolding,
    // medium configuration
    input  wire logic [63:0]   cfgMaxLba,
    input  wire logic [31:0]   cfgBlockLen,
    input  wire logic          cfgProtEn,
    input  wire logic [2:0]    cfgProtType,
    input  wire logic [3:0]    cfgPiExp,
    input  wire logic [3:0]    cfgLbppbExp,
    input  wire logic          cfgThinProvisioningEnabled,
    input  wire logic          cfgUnmappedReadsZero,
    input  wire logic [15:0]   cfgLowestAligned
);
    import ebcr_pkg::*;

    localparam int AW = (ECHO_DEPTH > 1) ? $clog2(ECHO_DEPTH) : 1;
    localparam int LW = $clog2(ECHO_DEPTH + 1);
    localparam logic [12:0] ECHO_CAP = 13'(ECHO_DEPTH - ECHO_DEPTH % 4);

    function automatic logic [63:0] cdbField(input logic [127:0] cdb,
                                             input int first,
                                             input int nb);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 0; i < 8; i++) begin
            if (i < nb) begin
                v = {v[55:0], cdb[127 - 8 * (first + i) -: 8]};
            end
        end
        return v;
    endfunction : cdbField

    // echo write state
    logic [LW-1:0] echoLen_q,     echoLen_d;
    logic          echoWritten_q, echoWritten_d;
    logic [LW-1:0] wrBase;
    logic          memWrEn;

    // command state
    ebcr_state_t   state_q,  state_d;
    ebcr_src_t     src_q,    src_d;
    logic [8:0]    idx_q,    idx_d;
    logic [8:0]    cnt_q,    cnt_d;
    logic          dinValid_q, dinValid_d;
    logic [7:0]    dinData_q,  dinData_d;
    logic          dinLast_q,  dinLast_d;
    logic          done_q,     done_d;
    logic          check_q,    check_d;
    logic [3:0]    sk_q,       sk_d;
    logic [7:0]    asc_q,      asc_d;
    logic          cmdReady_q, cmdReady_d;

    // decode and datapath helpers
    logic [7:0]    opcode;
    logic [4:0]    modeSa;
    logic [63:0]   rbOffset;
    logic [63:0]   rbAlloc;
    logic [15:0]   echoReq;
    logic [15:0]   echoMin;
    logic [63:0]   rc10Lba;
    logic [63:0]   rc16Lba;
    logic [63:0]   rc16Alloc;
    logic          rc10Pmi;
    logic          rc16Pmi;
    logic [63:0]   lbaRep;
    logic [31:0]   lba32;
    logic          protOn;
    logic [7:0]    protByte;
    logic [13:0]   alignedRep;
    logic [7:0]    memByte;
    logic [7:0]    capByte;
    logic [7:0]    srcByte;
    logic          advance;
    logic          lastByte;

    // echo capture; a new echo write restarts the count
    always_comb begin
        wrBase        = echoWrStart ? '0 : echoLen_q;
        memWrEn       = echoWrValid && (32'(wrBase) < ECHO_DEPTH);
        echoLen_d     = memWrEn ? LW'(wrBase + 1'b1) : wrBase;
        echoWritten_d = echoWritten_q | echoWrStart;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            echoLen_q     <= '0;
            echoWritten_q <= 1'b0;
        end else begin
            echoLen_q     <= echoLen_d;
            echoWritten_q <= echoWritten_d;
        end
    end

    // private store, shared by no other buffer mode
    ebcr_echo_mem #(
        .DEPTH (ECHO_DEPTH),
        .AW    (AW)
    ) u_echo_mem (
        .clk_sys (clk_sys),
        .wrEn    (memWrEn),
        .wrAddr  (AW'(wrBase)),
        .wrData  (echoWrData),
        .rdAddr  (AW'(idx_q)),
        .rdData  (memByte)
    );

    // field extraction
    always_comb begin
        opcode    = cmdCdb[127 - 8 * CDB_OPCODE -: 8];
        modeSa    = cmdCdb[124 - 8 * CDB_MODE_SA -: 5];
        rbOffset  = cdbField(cmdCdb, RB_OFFSET_BYTE, RB_OFFSET_LEN);
        rbAlloc   = cdbField(cmdCdb, RB_ALLOC_BYTE, RB_ALLOC_LEN);
        // upper two allocation bytes play no part in an echo read
        echoReq   = {8'h0, cmdCdb[127 - 8 * RB_ALLOC_LSB -: 8]};
        echoMin   = (echoReq < 16'(echoLen_q)) ? echoReq
                                               : 16'(echoLen_q);
        rc10Lba   = cdbField(cmdCdb, RC10_LBA_BYTE, RC10_LBA_LEN);
        rc10Pmi   = cmdCdb[120 - 8 * RC10_PMI_BYTE];
        rc16Lba   = cdbField(cmdCdb, RC16_LBA_BYTE, RC16_LBA_LEN);
        rc16Alloc = cdbField(cmdCdb, RC16_ALLOC_BYTE, RC16_ALLOC_LEN);
        rc16Pmi   = cmdCdb[120 - 8 * RC16_PMI_BYTE];
    end

    // capacity fields
    always_comb begin
        // both replies draw the lba from the same clamped value
        lbaRep = (cfgMaxLba > {16'h0, LBA_CEILING}) ? {16'h0, LBA_CEILING}
                                                    : cfgMaxLba;
        lba32  = (|lbaRep[63:32]) ? 32'hffff_ffff : lbaRep[31:0];
        // a reserved type code is reported as unprotected
        protOn   = cfgProtEn && (cfgProtType <= PTYPE_MAX);
        protByte = {4'h0, (protOn ? cfgProtType : 3'h0), protOn};
        alignedRep = (cfgLowestAligned > ALIGNED_MAX) ?
                     ALIGNED_MAX[13:0] : cfgLowestAligned[13:0];
    end

    ebcr_cap_fmt u_cap_fmt (
        .isLong                  (src_q == SRC_CAP16),
        .idx                     (idx_q[4:0]),
        .lba64                   (lbaRep),
        .lba32                   (lba32),
        .blockLen                (cfgBlockLen),
        .protByte                (protByte),
        .expByte                 ({cfgPiExp, cfgLbppbExp}),
        .thinProvisioningEnabled (cfgThinProvisioningEnabled),
        .unmappedReadsZero       (cfgUnmappedReadsZero),
        .lowestAligned           (alignedRep),
        .replyByte               (capByte)
    );

    // byte source for the data-in stream
    always_comb begin
        case (src_q)
            SRC_ECHO: srcByte = memByte;
            SRC_DESC: begin
                case (idx_q[1:0])
                    2'h0: srcByte =
                        {7'h0, ECHO_OVERWRITE_SUPPORTED_FLAG};
                    2'h2:    srcByte = {3'h0, ECHO_CAP[12:8]};
                    2'h3:    srcByte = ECHO_CAP[7:0];
                    default: srcByte = 8'h00;
                endcase
            end
            default:  srcByte = capByte;
        endcase
    end

    // command sequencer
    always_comb begin
        state_d    = state_q;
        src_d      = src_q;
        idx_d      = idx_q;
        cnt_d      = cnt_q;
        dinValid_d = dinValid_q && !dinReady;
        dinData_d  = dinData_q;
        dinLast_d  = dinLast_q;
        done_d     = 1'b0;
        check_d    = check_q;
        sk_d       = sk_q;
        asc_d      = asc_q;
        advance    = !dinValid_q || dinReady;
        lastByte   = (idx_q == cnt_q - 9'h001);
        case (state_q)
            ST_IDLE: begin
                if (cmdValid && cmdReady_q) begin
                    idx_d   = 9'h000;
                    cnt_d   = 9'h000;
                    check_d = 1'b1;
                    sk_d    = SK_ILLEGAL_REQ;
                    asc_d   = ASC_BAD_FIELD;
                    state_d = ST_STAT;
                    if (opcode == OPC_READ_BUFFER &&
                        (modeSa == MODE_ECHO_READ ||
                         modeSa == MODE_EXP_ECHO)) begin
                        // buffer id and offset deliberately unread
                        src_d = SRC_ECHO;
                        if (!echoWritten_q) begin
                            asc_d = ASC_SEQ_ERROR;
                        end else begin
                            check_d = 1'b0;
                            cnt_d   = echoMin[8:0];
                        end
                    end else if (opcode == OPC_READ_BUFFER &&
                                 modeSa == MODE_ECHO_DESC) begin
                        src_d = SRC_DESC;
                        if (rbOffset == 64'h0) begin
                            check_d = 1'b0;
                            cnt_d   = (rbAlloc < 64'(LEN_ECHO_DESC)) ?
                                      rbAlloc[8:0] : LEN_ECHO_DESC;
                        end
                    end else if (opcode == OPC_READ_CAP10) begin
                        src_d = SRC_CAP10;
                        if (rc10Pmi ? (rc10Lba <= lbaRep)
                                    : (rc10Lba == 64'h0)) begin
                            check_d = 1'b0;
                            cnt_d   = LEN_CAP10;
                        end
                    end else if (opcode == OPC_SVC_IN16 &&
                                 modeSa == SA_READ_CAP16) begin
                        src_d = SRC_CAP16;
                        if (rc16Pmi ? (rc16Lba <= lbaRep)
                                    : (rc16Lba == 64'h0)) begin
                            check_d = 1'b0;
                            cnt_d   = (rc16Alloc < 64'(LEN_CAP16)) ?
                                      rc16Alloc[8:0] : LEN_CAP16;
                        end
                    end else if (opcode != OPC_READ_BUFFER &&
                                 opcode != OPC_SVC_IN16) begin
                        asc_d = ASC_BAD_OPCODE;
                    end
                    if (!check_d) begin
                        sk_d  = SK_NONE;
                        asc_d = ASC_NONE;
                        if (cnt_d != 9'h000) begin
                            state_d = ST_SEND;
                        end
                    end
                end
            end
            ST_SEND: begin
                if (advance) begin
                    dinValid_d = 1'b1;
                    dinData_d  = srcByte;
                    dinLast_d  = lastByte;
                    idx_d      = idx_q + 9'h001;
                    if (lastByte) begin
                        state_d = ST_STAT;
                    end
                end
            end
            ST_STAT: begin
                // status only once the last byte has been taken
                if (advance) begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        cmdReady_d = (state_d == ST_IDLE) && !done_d;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            src_q      <= SRC_ECHO;
            idx_q      <= 9'h000;
            cnt_q      <= 9'h000;
            dinValid_q <= 1'b0;
            dinData_q  <= 8'h00;
            dinLast_q  <= 1'b0;
            done_q     <= 1'b0;
            check_q    <= 1'b0;
            sk_q       <= SK_NONE;
            asc_q      <= ASC_NONE;
            cmdReady_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            src_q      <= src_d;
            idx_q      <= idx_d;
            cnt_q      <= cnt_d;
            dinValid_q <= dinValid_d;
            dinData_q  <= dinData_d;
            dinLast_q  <= dinLast_d;
            done_q     <= done_d;
            check_q    <= check_d;
            sk_q       <= sk_d;
            asc_q      <= asc_d;
            cmdReady_q <= cmdReady_d;
        end
    end

    // status flag for software: echo data present
    logic echoHolding_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            echoHolding_q <= 1'b0;
        end else begin
            echoHolding_q <= echoWritten_d;
        end
    end

    assign cmdReady    = cmdReady_q;
    assign dinValid    = dinValid_q;
    assign dinData     = dinData_q;
    assign dinLast     = dinLast_q;
    assign doneValid   = done_q;
    assign doneCheck   = check_q;
    assign senseKey    = sk_q;
    assign senseAsc    = asc_q;
    assign echoHolding = echoHolding_q;
endmodule : ebcr_top

// *** test/ebcr_props.sv ***
// checker of port timing and completion status of the command handler
// assumes bind onto ebcr_top; one clock domain
`timescale 1ns/10ps
module ebcr_props
    import ebcr_pkg::*;
(
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         resetn,
    // command and echo write
    input wire logic         cmdValid,
    input wire logic [127:0] cmdCdb,
    input wire logic         cmdReady,
    input wire logic         echoWrStart,
    // data-in and completion
    input wire logic         dinValid,
    input wire logic [7:0]   dinData,
    input wire logic         dinLast,
    input wire logic         dinReady,
    input wire logic         doneValid,
    input wire logic         doneCheck,
    input wire logic [3:0]   senseKey,
    input wire logic [7:0]   senseAsc,
    input wire logic         echoHolding
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic take, echoRd, cap10;
    assign take   = cmdValid && cmdReady;
    assign echoRd = take && cmdCdb[127:120] == OPC_READ_BUFFER
                    && cmdCdb[116:112] == MODE_ECHO_READ;
    assign cap10  = take && cmdCdb[127:120] == OPC_READ_CAP10
                    && cmdCdb[111:80] == 32'h0 && !cmdCdb[56];

    property p_refuse; take |=> !cmdReady; endproperty
    a_refuse: assert property (p_refuse)
        else $error("ready stayed high after a take");
    property p_reopen; doneValid |=> cmdReady && !doneValid; endproperty
    a_reopen: assert property (p_reopen)
        else $error("completion not a pulse followed by ready");
    property p_hold;
        dinValid && !dinReady |=> dinValid && $stable(dinData)
            && $stable(dinLast);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data-in byte changed before acceptance");
    property p_lastDone;
        dinValid && dinReady && dinLast |=> doneValid && !dinValid;
    endproperty
    a_lastDone: assert property (p_lastDone)
        else $error("no completion after last byte");
    property p_first; cap10 |-> ##2 dinValid; endproperty
    a_first: assert property (p_first)
        else $error("short capacity reply not started in time");
    property p_errDone; take ##1 doneCheck |=> doneValid; endproperty
    a_errDone: assert property (p_errDone)
        else $error("check condition not completed in time");
    property p_noEcho;
        echoRd && !echoHolding && !echoWrStart |=> doneCheck
            && senseAsc == ASC_SEQ_ERROR;
    endproperty
    a_noEcho: assert property (p_noEcho)
        else $error("echo read without echo write not refused");
    property p_holding;
        echoWrStart || echoHolding |=> echoHolding;
    endproperty
    a_holding: assert property (p_holding)
        else $error("echo contents flag lost");
    property p_sense;
        doneValid |-> doneCheck ? senseKey == SK_ILLEGAL_REQ
            : senseKey == SK_NONE && senseAsc == ASC_NONE;
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense data does not match status");
    c_err: cover property (doneValid && doneCheck);
    c_stall: cover property (dinValid && !dinReady);
    c_cap10: cover property (cap10);
endmodule : ebcr_props

bind ebcr_top ebcr_props u_props (.clk_sys(clk_sys), .resetn(resetn),
    .cmdValid(cmdValid), .cmdCdb(cmdCdb), .cmdReady(cmdReady),
    .echoWrStart(echoWrStart), .dinValid(dinValid), .dinData(dinData),
    .dinLast(dinLast), .dinReady(dinReady), .doneValid(doneValid),
    .doneCheck(doneCheck), .senseKey(senseKey), .senseAsc(senseAsc),
    .echoHolding(echoHolding));

// *** test/ebcr_host.sv ***
// initiator side of the data-in stream: collects reply bytes
// assumes the bench sets slow to throttle acceptance
`timescale 1ns/10ps
module ebcr_host (
    // clock and throttle
    input  wire logic       clk_sys,
    input  wire logic       slow,
    // data-in stream
    input  wire logic       dinValid,
    input  wire logic [7:0] dinData,
    input  wire logic       dinLast,
    output logic            dinReady
);
    logic [7:0] got[$];
    int         lastAt;
    initial dinReady = 1'b1;
    // stall every other cycle so the hold path is exercised
    always @(negedge clk_sys) dinReady <= slow ? ~dinReady : 1'b1;
    always @(posedge clk_sys) begin
        if (dinValid && dinReady) begin
            got.push_back(dinData);
            if (dinLast) lastAt = got.size();
        end
    end
endmodule : ebcr_host

// *** test/ebcr_top_tb.sv ***
// self-checking bench of the echo-buffer and capacity command handler
// assumes ebcr_host as the initiator and ebcr_props bound to the design
`timescale 1ns/10ps
module ebcr_top_tb;
    import ebcr_pkg::*;
    localparam int DEPTH = 16;
    logic         clk_sys, resetn, slow, cmdValid, cmdReady;
    logic         echoWrStart, echoWrValid, dinValid, dinLast, dinReady;
    logic         doneValid, doneCheck, echoHolding, cfgProtEn;
    logic         cfgThin, cfgZero;
    logic [127:0] cmdCdb;
    logic [7:0]   echoWrData, dinData, senseAsc;
    logic [3:0]   senseKey, cfgPiExp, cfgLbppbExp;
    logic [63:0]  cfgMaxLba;
    logic [31:0]  cfgBlockLen;
    logic [2:0]   cfgProtType;
    logic [15:0]  cfgLowestAligned;
    logic [7:0]   exp[$];
    int           err_total, checked;

    ebcr_top #(.ECHO_DEPTH(DEPTH)) DUT (.clk_sys(clk_sys), .resetn(resetn),
        .cmdValid(cmdValid), .cmdCdb(cmdCdb), .cmdReady(cmdReady),
        .echoWrStart(echoWrStart), .echoWrValid(echoWrValid),
        .echoWrData(echoWrData), .dinValid(dinValid), .dinData(dinData),
        .dinLast(dinLast), .dinReady(dinReady), .doneValid(doneValid),
        .doneCheck(doneCheck), .senseKey(senseKey), .senseAsc(senseAsc),
        .echoHolding(echoHolding), .cfgMaxLba(cfgMaxLba),
        .cfgBlockLen(cfgBlockLen), .cfgProtEn(cfgProtEn),
        .cfgProtType(cfgProtType), .cfgPiExp(cfgPiExp),
        .cfgLbppbExp(cfgLbppbExp), .cfgThinProvisioningEnabled(cfgThin),
        .cfgUnmappedReadsZero(cfgZero), .cfgLowestAligned(cfgLowestAligned));
    ebcr_host host (.clk_sys(clk_sys), .slow(slow), .dinValid(dinValid),
        .dinData(dinData), .dinLast(dinLast), .dinReady(dinReady));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic void put(input logic [63:0] v, input int nb);
        for (int i = nb - 1; i >= 0; i--) exp.push_back(v[8*i +: 8]);
    endfunction : put

    function automatic logic [127:0] rb(input logic [4:0] m,
                                        input logic [23:0] off, al);
        return {OPC_READ_BUFFER, 3'h0, m, 8'h05, off, al, 56'h0};
    endfunction : rb

    function automatic logic [127:0] c10(input logic [31:0] a,
                                         input logic p);
        return {OPC_READ_CAP10, 8'h0, a, 16'h0, 7'h0, p, 56'h0};
    endfunction : c10

    // one command, then status and reply compared against exp
    task automatic run(input logic [127:0] c, input logic ck,
                       input logic [7:0] asc);
        int n;
        n = 0;
        host.got.delete();
        host.lastAt = 0;
        @(negedge clk_sys);
        cmdCdb   = c;
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        cmdValid = 1'b0;
        while (doneValid !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("Error at %0t: command never completed", $time);
            test_done();
        end
        chk(doneCheck, ck);
        chk(senseKey, ck ? SK_ILLEGAL_REQ : SK_NONE);
        chk(senseAsc, asc);
        chk(host.got.size(), exp.size());
        chk(host.lastAt, exp.size());
        foreach (exp[i]) chk(host.got[i], exp[i]);
        exp.delete();
    endtask : run

    task automatic ewrite(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            echoWrStart = (i == 0);
            echoWrValid = 1'b1;
            echoWrData  = 8'ha0 + i[7:0];
        end
        @(negedge clk_sys);
        echoWrStart = 1'b0;
        echoWrValid = 1'b0;
    endtask : ewrite

    task automatic t_echo;
        logic [4:0] md[2];
        md = '{MODE_ECHO_READ, MODE_EXP_ECHO};
        run(rb(MODE_ECHO_READ, 24'h0, 24'h10), 1'b1, ASC_SEQ_ERROR);
        ewrite(6);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) exp.push_back(8'ha0 + i[7:0]);
            // high length bytes and offset ignored
            run(rb(md[k], 24'h123, 24'h030404), 1'b0,
                ASC_NONE);
        end
    endtask : t_echo

    task automatic t_desc;
        put(64'(DEPTH - DEPTH % 4), 4);
        run(rb(MODE_ECHO_DESC, 24'h0, 24'h4), 1'b0, ASC_NONE);
        put(64'h0, 2);
        run(rb(MODE_ECHO_DESC, 24'h0, 24'h2), 1'b0, ASC_NONE);
        run(rb(MODE_ECHO_DESC, 24'h1, 24'h4), 1'b1, ASC_BAD_FIELD);
        // length of 12 cut by the design to the 6 bytes written
        for (int i = 0; i < 6; i++) exp.push_back(8'ha0 + i[7:0]);
        run(rb(MODE_ECHO_READ, 24'h0, 24'h0c), 1'b0,
            ASC_NONE);
    endtask : t_desc

    task automatic t_cap10;
        cfgMaxLba = 64'h1234;
        for (int p = 0; p < 2; p++) begin
            put(64'h1234, 4);
            put(64'(cfgBlockLen), 4);
            run(c10(p ? 32'h1234 : 32'h0, p[0]), 1'b0,
                ASC_NONE);
        end
        run(c10(32'h1, 1'b0), 1'b1, ASC_BAD_FIELD);
        run(c10(32'h1235, 1'b1), 1'b1, ASC_BAD_FIELD);
        run(128'h0, 1'b1, ASC_BAD_OPCODE);
    endtask : t_cap10

    task automatic t_cap16;
        logic [7:0] b12;
        cfgMaxLba = 64'hffff_0000_0000_0001;
        for (int k = 0; k < 5; k++) begin
            slow        = (k == 0);
            cfgProtEn   = (k < 4);
            cfgProtType = (k < 4) ? k[2:0] : 3'h1;
            b12 = (k < 3) ? {4'h0, k[2:0], 1'b1} : 8'h0;
            put({16'h0, LBA_CEILING}, 8);
            put(64'(cfgBlockLen), 4);
            put({b12, 8'h32, 2'b10, 6'h3f, 8'hff}, 4);
            put(64'h0, 8);
            put(64'h0, 8);
            if (k > 0) while (exp.size() > 13) void'(exp.pop_back());
            run({OPC_SVC_IN16, 3'h0, SA_READ_CAP16, 64'h0,
                 (k > 0) ? 32'd13 : 32'd32, 16'h0}, 1'b0, ASC_NONE);
        end
        slow = 1'b0;
        run({OPC_SVC_IN16, 3'h0, SA_READ_CAP16, 64'h5, 32'd32, 16'h0},
            1'b1, ASC_BAD_FIELD);
    endtask : t_cap16

    initial begin
        {resetn, slow, cmdValid, echoWrStart, echoWrValid} = 5'h0;
        {cmdCdb, echoWrData, cfgMaxLba, cfgProtEn, cfgProtType} = '0;
        {err_total, checked} = '0;
        cfgBlockLen      = 32'h200;
        cfgPiExp         = 4'h3;
        cfgLbppbExp      = 4'h2;
        cfgThin          = 1'b1;
        cfgZero          = 1'b0;
        cfgLowestAligned = 16'h4005;
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        t_echo();
        t_desc();
        t_cap10();
        t_cap16();
        test_done();
    end
endmodule : ebcr_top_tb
